// ==== hdl/qsw_cfg_defines.vh ====
// Purpose: Constants for the quad switch serial configuration registers
// Assumes: 16-bit frames, address in bits 12:8 of a frame
// Notes:   Times in their own units, cycle counts derived at 50 MHz
`ifndef QSW_CFG_DEFINES_VH
`define QSW_CFG_DEFINES_VH

// ************************************************************
// Frame layout
// ************************************************************
`define QSW_FRAME_BITS     16
`define QSW_WD_BIT         15
`define QSW_SEL_HI         12
`define QSW_SEL_LO         11
`define QSW_REG_HI         10
`define QSW_REG_LO         8
`define QSW_ADDR_HI        12
`define QSW_ADDR_LO        8

// ************************************************************
// Register codes
// ************************************************************
`define QSW_REG_TRIP       3'h2
`define QSW_REG_BLANK      3'h3
`define QSW_REG_DIRECT     3'h4
`define QSW_ADDR_SUPPLY    5'h05
`define QSW_ADDR_NOACT     5'h06
`define QSW_ADDR_WDOG      5'h0d

// ************************************************************
// Field positions
// ************************************************************
`define QSW_TRIP_HIGH      3
`define QSW_BLK_LOW_DIS    2
`define QSW_BLK_OL_DIS     3
`define QSW_DIR_ANDOR      0
`define QSW_DIR_PIN_DIS    1
`define QSW_DIR_SENSE      2
`define QSW_DIR_FAST       3

// ************************************************************
// Reset values
// ************************************************************
`define QSW_CFG_RESET      4'h0

// ************************************************************
// Timing
// ************************************************************
`define QSW_CLK_KHZ        50000
`define QSW_BLANK0_MS      155
`define QSW_BLANK2_MS      75
`define QSW_BLANK3_US      150
`define QSW_HIGH_TRIP_US   20
`define QSW_WD0_MS         558
`define QSW_WD1_MS         279
`define QSW_WD2_MS         2250
`define QSW_WD3_MS         1125
`define QSW_MS_CYC(ms)     ((ms) * `QSW_CLK_KHZ)
`define QSW_US_CYC(us)     (((us) * `QSW_CLK_KHZ) / 1000)

`endif

// ==== hdl/qsw_cfg_regs.v ====
// Purpose: Serial configuration register bank of a four channel high side switch
// Assumes: Link clock and pins sampled by mclk; link clock at most mclk/4
// Notes:   Frames shift MSB first on rising link clock, commit on select release
//
// Behaviour
// [RULE_01] Per-channel writes go to channel chosen by bits 12:11, each independent
// [RULE_02] Low trip code in bits 2:0 selects eight levels, 18.2 A down to 4.8 A
// [RULE_03] High trip bit 3 selects 100 A when zero, 70 A when one
// [RULE_04] Blanking code: 00 155 ms, 10 75 ms, 11 150 us; host avoids 01
// [RULE_05] High level reached latches channel off within 20 us, no blanking
// [RULE_06] Low trip disable bit stops low detection and blanking timeout
// [RULE_07] Open load disable bit turns off open load detection for channel
// [RULE_08] Pin control disable bit zero lets input pin control channel
// [RULE_09] With pin control, bit 0 one ANDs pin with serial bit, zero ORs
// [RULE_10] Sense ratio bit selects 1/13000 when zero, 1/38000 when one
// [RULE_11] Fast edge bit selects fast slew when one, slow when zero
// [RULE_12] Supply register bit 1 disables undervoltage, bit 0 overvoltage
// [RULE_13] Supply register bits 3:2 both one disable thermal latching channels 0,1
// [RULE_14] Watchdog register bits 3:2 both one disable thermal latching channels 2,3
// [RULE_15] Timeout code: 00 558 ms, 01 279 ms, 10 2250 ms, 11 1125 ms
// [RULE_16] Host toggles watchdog bit when writing a new timeout
// [RULE_17] No-action frames change nothing, but watchdog bit toggle restarts count
// [RULE_18] Address 00101 decodes supply protection register
// [RULE_19] Address 01101 decodes watchdog register
// [RULE_20] Address 00110 decodes no-action register
// [RULE_21] Only multiples of 16 bits accepted; other lengths change nothing
// [RULE_22] Select rising after valid length latches last frame into register
// [RULE_23] Reset clears every configuration bit
`timescale 1ns/1ps
`default_nettype none
`include "qsw_cfg_defines.vh"

module qsw_cfg_regs #(
  parameter integer NCH = 4
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         arst_n,
  input  wire         clk_en,
  // Serial link pins
  input  wire         sclk,
  input  wire         cs_n,
  input  wire         sdi,
  // Channel inputs
  input  wire [3:0]   in_pin,
  input  wire [3:0]   serial_on,
  input  wire [3:0]   low_over,
  input  wire [3:0]   high_over,
  // Channel configuration
  output reg  [11:0]  low_trip_code,
  output reg  [3:0]   high_trip_select,
  output reg  [3:0]   low_trip_disable,
  output reg  [3:0]   open_load_disable,
  output reg  [3:0]   pin_control_disable,
  output reg  [3:0]   sense_ratio_select,
  output reg  [3:0]   fast_edge_select,
  output reg  [3:0]   switch_on,
  output reg  [3:0]   latch_off,
  // Global configuration
  output reg          low_supply_protect_off,
  output reg          high_supply_protect_off,
  output reg  [3:0]   thermal_latch_off,
  output reg  [1:0]   timeout_code,
  output reg          watchdog_kick
);

  // ************************************************************
  // Timing constants
  // ************************************************************
  localparam [31:0] BLK0_CYC  = `QSW_MS_CYC(`QSW_BLANK0_MS);
  localparam [31:0] BLK2_CYC  = `QSW_MS_CYC(`QSW_BLANK2_MS);
  localparam [31:0] BLK3_CYC  = `QSW_US_CYC(`QSW_BLANK3_US);
  localparam [31:0] HIGH_CYC  = `QSW_US_CYC(`QSW_HIGH_TRIP_US);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg  [2:0] s1_q;
  reg  [2:0] s2_q;
  reg        sclk_d1_q;
  reg  [3:0] in1_q;
  reg  [3:0] in2_q;
  reg        cs_d1_q;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Idle levels: select high, link clock low, so no false edge follows reset
      s1_q      <= 3'h4;
      s2_q      <= 3'h4;
      sclk_d1_q <= 1'b0;
      cs_d1_q   <= 1'b1;
      in1_q     <= 4'h0;
      in2_q     <= 4'h0;
    end
    else if (clk_en)
    begin
      s1_q      <= {cs_n, sclk, sdi};
      s2_q      <= s1_q;
      sclk_d1_q <= s2_q[1];
      cs_d1_q   <= s2_q[2];
      in1_q     <= in_pin;
      in2_q     <= in1_q;
    end
  end

  wire sclk_rise = s2_q[1] & ~sclk_d1_q;
  wire cs_rise   = s2_q[2] & ~cs_d1_q;

  // ************************************************************
  // Receive shifter and length count
  // ************************************************************
  reg  [15:0] shift_q;
  reg  [3:0]  bitcnt_q;
  reg         any_q;
  reg         wd_last_q;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_q  <= 16'h0000;
      bitcnt_q <= 4'h0;
      any_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cs_rise)
      begin
        bitcnt_q <= 4'h0;
        any_q    <= 1'b0;
      end
      else if (!s2_q[2] && sclk_rise)
      begin
        shift_q  <= {shift_q[14:0], s2_q[0]};
        bitcnt_q <= bitcnt_q + 4'h1;
        any_q    <= 1'b1;
      end
    end
  end

  // Wrapped count of zero with bits seen means a whole multiple of 16
  wire        frame_ok = cs_rise & any_q & (bitcnt_q == 4'h0); // RULE_21
  wire [4:0]  addr     = shift_q[`QSW_ADDR_HI:`QSW_ADDR_LO];
  wire [2:0]  rsel     = shift_q[`QSW_REG_HI:`QSW_REG_LO];
  wire [1:0]  chan     = shift_q[`QSW_SEL_HI:`QSW_SEL_LO];
  wire [3:0]  data     = shift_q[3:0];

  // ************************************************************
  // Blanking period decode
  // ************************************************************
  function [31:0] blank_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0:    blank_cycles = BLK0_CYC; // RULE_04
        2'h2:    blank_cycles = BLK2_CYC;
        2'h3:    blank_cycles = BLK3_CYC;
        default: blank_cycles = BLK0_CYC; // Unsupported code, longest safe
      endcase
    end
  endfunction

  // ************************************************************
  // Register decode
  // ************************************************************
  // Shared by the per-channel writes and the AND/OR select
  function reg_hit;
    input       ok;
    input [2:0] code;
    input [2:0] want;
    begin
      reg_hit = ok & (code == want);
    end
  endfunction

  // ************************************************************
  // AND/OR select per channel
  // ************************************************************
  reg [3:0] blank_code_and_q;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      blank_code_and_q <= 4'h0;
    else if (clk_en && reg_hit(frame_ok, rsel, `QSW_REG_DIRECT))
      blank_code_and_q[chan] <= data[`QSW_DIR_ANDOR]; // RULE_09
  end

  // ************************************************************
  // Global registers
  // ************************************************************
  reg [1:0] blank_code_q [0:NCH-1];

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_supply_protect_off  <= 1'b0; // RULE_23
      high_supply_protect_off <= 1'b0;
      thermal_latch_off       <= 4'h0;
      timeout_code            <= 2'h0;
      watchdog_kick           <= 1'b0;
      wd_last_q               <= 1'b0;
    end
    else if (clk_en)
    begin
      watchdog_kick <= 1'b0;
      if (frame_ok)
      begin // RULE_22
        wd_last_q <= shift_q[`QSW_WD_BIT];
        // Any valid frame, including no-action, may restart the count
        watchdog_kick <= shift_q[`QSW_WD_BIT] ^ wd_last_q; // RULE_17
        if (addr == `QSW_ADDR_SUPPLY)
        begin // RULE_18
          low_supply_protect_off  <= data[1]; // RULE_12
          high_supply_protect_off <= data[0];
          thermal_latch_off[1:0]  <= {2{data[3] & data[2]}}; // RULE_13
        end
        if (addr == `QSW_ADDR_WDOG)
        begin // RULE_19
          timeout_code           <= data[1:0]; // RULE_15
          thermal_latch_off[3:2] <= {2{data[3] & data[2]}}; // RULE_14
        end
        // No-action address falls through every decode untouched // RULE_20
      end
    end
  end

  // ************************************************************
  // Per-channel registers and protection timers
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      reg [31:0] low_cnt_q;
      reg [31:0] high_cnt_q;
      localparam integer CHI = g;
      // Channel field doubles as the top of the address, so one compare routes the write
      wire hit       = frame_ok & (chan == CHI[1:0]); // RULE_01
      wire hit_trip  = reg_hit(hit, rsel, `QSW_REG_TRIP);
      wire hit_blank = reg_hit(hit, rsel, `QSW_REG_BLANK);
      wire hit_dir   = reg_hit(hit, rsel, `QSW_REG_DIRECT);

      always @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          low_trip_code[3*g+2:3*g] <= 3'h0;
          high_trip_select[g]      <= 1'b0;
          low_trip_disable[g]      <= 1'b0;
          open_load_disable[g]     <= 1'b0;
          pin_control_disable[g]   <= 1'b0;
          sense_ratio_select[g]    <= 1'b0;
          fast_edge_select[g]      <= 1'b0;
          blank_code_q[g]          <= 2'h0;
          switch_on[g]             <= 1'b0;
          latch_off[g]             <= 1'b0;
          low_cnt_q                <= 32'h0;
          high_cnt_q               <= 32'h0;
        end
        else if (clk_en)
        begin
          if (hit_trip)
          begin
            low_trip_code[3*g+2:3*g] <= data[2:0]; // RULE_02
            high_trip_select[g]      <= data[`QSW_TRIP_HIGH]; // RULE_03
          end
          if (hit_blank)
          begin
            blank_code_q[g]      <= data[1:0]; // RULE_04
            low_trip_disable[g]  <= data[`QSW_BLK_LOW_DIS]; // RULE_06
            open_load_disable[g] <= data[`QSW_BLK_OL_DIS]; // RULE_07
          end
          if (hit_dir)
          begin
            pin_control_disable[g] <= data[`QSW_DIR_PIN_DIS]; // RULE_08
            sense_ratio_select[g]  <= data[`QSW_DIR_SENSE]; // RULE_10
            fast_edge_select[g]    <= data[`QSW_DIR_FAST]; // RULE_11
          end
          // Combine pin and serial command
          if (pin_control_disable[g])
            switch_on[g] <= serial_on[g] & ~latch_off[g]; // RULE_08
          else if (blank_code_and_q[g])
            switch_on[g] <= serial_on[g] & in2_q[g] & ~latch_off[g]; // RULE_09
          else
            switch_on[g] <= (serial_on[g] | in2_q[g]) & ~latch_off[g]; // RULE_09
          // Latched fault clears when serial command is off and the pin is low or ignored
          if (!serial_on[g] && (pin_control_disable[g] || !in2_q[g]))
            latch_off[g] <= 1'b0;
          else if (high_cnt_q >= HIGH_CYC - 32'h1)
            latch_off[g] <= 1'b1; // RULE_05
          else if (!low_trip_disable[g] && low_cnt_q >= blank_cycles(blank_code_q[g]) - 32'h1)
            latch_off[g] <= 1'b1; // RULE_04
          // High trip ignores blanking; timer far below its limit
          high_cnt_q <= high_over[g] ? high_cnt_q + 32'h1 : 32'h0; // RULE_05
          low_cnt_q  <= (low_over[g] && !low_trip_disable[g]) ? low_cnt_q + 32'h1 : 32'h0; // RULE_06
        end
      end
    end
  endgenerate

endmodule // qsw_cfg_regs
`default_nettype wire

// ==== tb/qsw_cfg_checker.sv ====
// Purpose: Port assertions for the switch configuration bank
// Assumes: One mclk domain, async active low reset
// Notes:   Channel 0 stands for the fault checks
`timescale 1ns/1ps
`default_nettype none
module qsw_cfg_checker (
  // Clock, reset and link select
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic        cs_n,
  // Channel fault path
  input wire logic [3:0]  high_over,
  input wire logic [3:0]  switch_on,
  input wire logic [3:0]  latch_off,
  input wire logic [3:0]  low_trip_disable,
  // Configuration
  input wire logic [11:0] low_trip_code,
  input wire logic [3:0]  high_trip_select,
  input wire logic [3:0]  open_load_disable,
  input wire logic [3:0]  pin_control_disable,
  input wire logic [3:0]  sense_ratio_select,
  input wire logic [3:0]  fast_edge_select,
  input wire logic [3:0]  thermal_latch_off,
  input wire logic        low_supply_protect_off,
  input wire logic        high_supply_protect_off,
  input wire logic        watchdog_kick,
  input wire logic [1:0]  timeout_code
);
  wire [43:0] cfg = {low_trip_code, high_trip_select, low_trip_disable, open_load_disable,
    pin_control_disable, sense_ratio_select, fast_edge_select, low_supply_protect_off,
    high_supply_protect_off, thermal_latch_off, timeout_code};
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_low4; !cs_n [*4]; endsequence
  sequence s_calm; !high_over[0] ##1 !high_over[0]; endsequence
  property p_kick; watchdog_kick |=> !watchdog_kick; endproperty
  property p_ksrc; watchdog_kick |-> $past(cs_n) && $past(cs_n, 3); endproperty
  property p_upd; !$stable(cfg) |-> $past(cs_n, 2) && $past(cs_n, 3); endproperty
  property p_quiet; s_low4 |-> $stable(cfg); endproperty
  property p_rst; $rose(arst_n) |-> cfg == 44'h0 && latch_off == 4'h0; endproperty
  property p_frz; !clk_en |=> $stable(cfg); endproperty
  property p_high; $rose(high_over[0]) && switch_on[0] |-> ##[1:1000] latch_off[0]; endproperty
  property p_ldis; s_calm ##0 low_trip_disable[0] |=> !$rose(latch_off[0]); endproperty
  a_kick: assert property (p_kick)
    else $error("kick wider than one cycle");
  a_ksrc: assert property (p_ksrc)
    else $error("kick without frame end");
  a_upd: assert property (p_upd)
    else $error("config moved while selected");
  a_quiet: assert property (p_quiet)
    else $error("config moved mid frame");
  a_rst: assert property (p_rst)
    else $error("config not cleared by reset");
  a_frz: assert property (p_frz)
    else $error("config moved while frozen");
  a_high: assert property (p_high)
    else $error("high trip too slow");
  a_ldis: assert property (p_ldis)
    else $error("low trip latched while off");
endmodule // qsw_cfg_checker
bind qsw_cfg_regs qsw_cfg_checker u_chk (.mclk, .arst_n, .clk_en, .cs_n, .high_over, .switch_on,
  .latch_off, .low_trip_disable, .low_trip_code, .high_trip_select, .open_load_disable,
  .pin_control_disable, .sense_ratio_select, .fast_edge_select, .thermal_latch_off,
  .low_supply_protect_off, .high_supply_protect_off, .watchdog_kick, .timeout_code);
`default_nettype wire

// ==== tb/qsw_host_model.sv ====
// Purpose: Host master driving frames of any bit count into the switch bank
// Assumes: Link clock 160 ns, idle low, data set on falling edge
// Notes:   Data line shows inverted last bit while deselected
`timescale 1ns/1ps
`default_nettype none
module qsw_host_model (
  // Clock
  input  wire logic mclk,
  // Link pins
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic sdi
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // Any bit count may be sent, so refused lengths can be tried
  task automatic send(input logic [31:0] w, input int nb);
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      sdi  <= w[i];
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    repeat (8) @(posedge mclk);
  endtask
endmodule // qsw_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the switch configuration bank
// Assumes: Host model sends frames, expected state kept here
// Notes:   Blanking code 11 keeps the fault timing run short
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, arst_n = 0, clk_en = 0, wd = 0;
  logic [3:0] in_pin = 0, serial_on = 0, low_over = 0, high_over = 0, sup = 0, wdg = 0;
  logic [3:0] st[3][4];
  logic [1:0] m;
  wire sclk, cs_n, sdi, lsp, hsp, watchdog_kick;
  wire [11:0] ltc;
  wire [3:0] hts, ltd, old, pcd, srs, fes, switch_on, latch_off, tlo;
  wire [1:0] tmo;
  wire [43:0] got = {ltc, hts, ltd, old, pcd, srs, fes, lsp, hsp, tlo, tmo};
  logic [43:0] expq[$];
  int num_errors = 0, samples_checked = 0, kicks = 0, i, n;
  always #10 mclk = ~mclk;
  qsw_host_model u_qsw_host_model (.mclk, .sclk, .cs_n, .sdi);
  qsw_cfg_regs u_qsw_cfg_regs (.mclk, .arst_n, .clk_en, .sclk, .cs_n, .sdi, .in_pin, .serial_on,
    .low_over, .high_over, .low_trip_code(ltc), .high_trip_select(hts), .low_trip_disable(ltd),
    .open_load_disable(old), .pin_control_disable(pcd), .sense_ratio_select(srs),
    .fast_edge_select(fes), .switch_on, .latch_off, .low_supply_protect_off(lsp),
    .high_supply_protect_off(hsp), .thermal_latch_off(tlo), .timeout_code(tmo), .watchdog_kick);
  function automatic logic [43:0] ex();
    logic [11:0] t;
    logic [3:0] h, ld, ol, pd, sr, fe;
    for (int k = 0; k < 4; k++)
    begin
      {t[3*k+:3], h[k]} = {st[0][k][2:0], st[0][k][3]};
      {ol[k], ld[k], fe[k], sr[k], pd[k]} = {st[1][k][3:2], st[2][k][3:1]};
    end
    return {t, h, ld, ol, pd, sr, fe, sup[1:0], {2{&wdg[3:2]}}, {2{&sup[3:2]}}, wdg[1:0]};
  endfunction
  task cmp(input logic [43:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cmp_bit(input logic g, e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cmp_cnt(input int g, e);
    samples_checked++;
    if (g != e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bench copy of the registers, cleared with every device reset
  task clr_model;
    for (int a = 0; a < 3; a++)
      for (int c = 0; c < 4; c++)
        st[a][c] = 4'h0;
    sup = 4'h0;
    wdg = 4'h0;
    wd  = 1'b0;
  endtask
  task xfer(input logic [31:0] w, input int nb);
    expq.push_back(ex());
    u_qsw_host_model.send(w, nb);
  endtask
  task wr(input logic [4:0] a, input logic [3:0] d, input logic tog);
    wd ^= tog;
    if (a[2:0] >= 2 && a[2:0] <= 4) st[a[2:0]-2][a[4:3]] = d;
    else if (a == 5) sup = d;
    else if (a == 13) wdg = d;
    xfer({16'h0, wd, 2'b0, a, 4'h0, d}, 16);
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) if (watchdog_kick === 1'b1) kicks++;
  always @(posedge cs_n)
    if (expq.size() > 0)
    begin
      repeat (6) @(posedge mclk);
      cmp(got, expq.pop_front());
    end
  // Tests need about 21k cycles; a hang ends well inside the cycle budget
  initial
  begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    close_out;
  end
  initial
  begin
    void'($urandom(32'hd7952bd8));
    clr_model;
    repeat (12) @(posedge mclk);
    arst_n <= 1;
    clk_en <= 1;
    repeat (3) @(posedge mclk);
    cmp(got, 44'h0);
    cmp_bit(|{switch_on, latch_off, watchdog_kick}, 1'b0);
    // A whole frame while frozen must leave every register alone
    clk_en <= 0;
    xfer({16'h0, 3'b0, 5'h05, 8'h0f}, 16);
    clk_en <= 1;
    tend("reset");
    for (i = 0; i < 12; i++)
    begin
      n = $urandom;
      if (i % 3 == 1 && n[1:0] == 2'b01) n[0] = 0;
      wr({i[3:2], 3'(i % 3 + 2)}, n[3:0], 1);
    end
    tend("channels");
    wr(5, 4'b1110, 1);
    wr(5, 4'b0001, 1);
    for (i = 0; i < 4; i++) wr(13, {{2{i[0]}}, i[1:0]}, 1);
    n = kicks;
    wr(6, 4'hf, 1);
    wr(6, 4'h5, 0);
    cmp_cnt(kicks - n, 1);
    xfer(32'h7fff, 15);
    xfer(32'h1ffff, 17);
    wd ^= 1;
    sup = 4'h3;
    xfer({16'h0600, wd, 2'b0, 5'h05, 8'h03}, 32);
    tend("frames");
    // Reset in mid run must clear what the tests above wrote
    arst_n <= 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1;
    clr_model;
    repeat (3) @(posedge mclk);
    cmp(got, 44'h0);
    for (i = 0; i < 12; i++)
    begin
      m = 2'(i / 4);
      if (i % 4 == 0) wr(4, {2'b0, m}, 1);
      in_pin[0] <= i[0];
      serial_on[0] <= i[1];
      repeat (8) @(posedge mclk);
      cmp_bit(switch_on[0], m[1] ? i[1] : m[0] ? i[0] & i[1] : i[0] | i[1]);
    end
    tend("direct");
    wr(3, 4'b0011, 1);
    serial_on[0] <= 1;
    repeat (8) @(posedge mclk);
    low_over[0] <= 1;
    for (n = 0; latch_off[0] !== 1'b1 && n < 9000; n++) @(posedge mclk);
    cmp_bit(n > 7450 && n < 7550, 1'b1);
    low_over[0] <= 0;
    serial_on[0] <= 0;
    repeat (8) @(posedge mclk);
    cmp_bit(latch_off[0], 1'b0);
    wr(3, 4'b0111, 1);
    serial_on[0] <= 1;
    low_over[0] <= 1;
    repeat (8000) @(posedge mclk);
    cmp_bit(latch_off[0], 1'b0);
    high_over[0] <= 1;
    for (n = 0; latch_off[0] !== 1'b1 && n < 1100; n++) @(posedge mclk);
    // The loop sees each edge's result one edge late, so n is one above the delay
    cmp_bit(n - 1 <= 1000, 1'b1);
    tend("faults");
    close_out;
  end
endmodule // testbench
`default_nettype wire
